/* File: core/motion_mode_command_decoder.sv */
`timescale 1ns/1ps
`include "motion_consts.svh"

// How it works
// - torque mode filters data register 12
// - torque mode command is four words
// - velocity input mode uses register 12
// - filter coefficient over 32768, 120 us update
// - program velocity ramps at given acceleration
// - program velocity command is seven words
// - program motion ends once velocity and target are both zero
// - stop condition ramps program velocity to zero, zeroes input modes at once, ends motion
// - serial command while busy gets busy NAK
// - multitasking replaces running motion immediately
// - register move command is four words
// - register moves act like immediate moves
module motion_mode_command_decoder (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst,
   // Avalon-MM slave
   input  wire logic [8:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   input  wire logic [3:0]          byteenable,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   // Stop inputs from pins
   input  wire logic [15:0]         stopPins,
   // Servo drive
   output motion_pkg::mode_t        driveMode,
   output logic      [31:0]         driveCmd,
   // Trajectory unit for absolute moves
   output logic                     moveStart,
   output logic                     moveAbort,
   output logic                     moveTimed,
   output logic      [31:0]         movePos,
   output logic      [31:0]         moveSecond,
   output logic      [31:0]         moveThird,
   output logic      [15:0]         moveStopEn,
   output logic      [15:0]         moveStopSt,
   input  wire logic                moveDone
);
   import motion_pkg::*;

   logic [15:0]         pinMeta, pinSync;
   logic [31:0]         dataReg [0:`DATA_REGS-1];
   logic [31:0]         next_dataReg [0:`DATA_REGS-1];
   logic [31:0]         ctrl, next_ctrl;
   eng_state_t          state, next_state;
   logic [15:0]         word [0:6];
   logic [15:0]         next_word [0:6];
   logic [2:0]          cnt, next_cnt, len, next_len;
   logic                fromProg, next_fromProg;
   resp_t               resp, next_resp;
   mode_t               mode, next_mode;
   logic signed [31:0]  filt, next_filt;
   logic [15:0]         filtK, next_filtK;
   logic [15:0]         stopEn, next_stopEn, stopSt, next_stopSt;
   logic signed [31:0]  curVel, next_curVel, target, next_target;
   logic [31:0]         accel, next_accel;
   logic [`TICK_W-1:0]  tickCnt, next_tickCnt;
   logic                next_moveStart, next_moveAbort, next_moveTimed;
   logic [31:0]         next_movePos, next_moveSecond, next_moveThird;
   logic [15:0]         next_moveStopEn, next_moveStopSt;
   logic [31:0]         next_driveCmd, next_readdata;
   logic                rdValid, next_rdValid;
   logic                cmdWrite, isCmdAddr, tick, stopMet, busy;
   logic [7:0]          opcode;
   logic [`DATA_IDX_W-1:0] base;
   logic signed [32:0]  diff;
   logic signed [49:0]  prod;
   logic signed [33:0]  stepUp, stepDn;

   // Pins cross into the clock domain
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinMeta <= 16'h0000;
         pinSync <= 16'h0000;
      end else begin
         pinMeta <= stopPins;
         pinSync <= pinMeta;
      end
   end

   assign isCmdAddr   = (address == `OFS_CMD_SERIAL) || (address == `OFS_CMD_PROGRAM);
   assign cmdWrite    = write && isCmdAddr && (state == ST_COLLECT);
   assign waitrequest = (read && !rdValid) || (write && isCmdAddr && (state != ST_COLLECT));
   assign tick        = (tickCnt == `TICK_W'(`UPDATE_CYC - 1));
   assign stopMet     = (stopEn != 16'h0000) && ((pinSync & stopEn) == (stopSt & stopEn));
   assign busy        = (mode != MODE_IDLE);
   assign opcode      = word[0][7:0];
   assign base        = word[1][`DATA_IDX_W-1:0];

   always_comb begin
      next_dataReg    = dataReg;
      next_ctrl       = ctrl;
      next_state      = state;
      next_word       = word;
      next_cnt        = cnt;
      next_len        = len;
      next_fromProg   = fromProg;
      next_resp       = resp;
      next_mode       = mode;
      next_filt       = filt;
      next_filtK      = filtK;
      next_stopEn     = stopEn;
      next_stopSt     = stopSt;
      next_curVel     = curVel;
      next_target     = target;
      next_accel      = accel;
      next_tickCnt    = tick ? `TICK_W'(0) : tickCnt + `TICK_W'(1);
      next_moveStart  = 1'b0;
      next_moveAbort  = 1'b0;
      next_moveTimed  = moveTimed;
      next_movePos    = movePos;
      next_moveSecond = moveSecond;
      next_moveThird  = moveThird;
      next_moveStopEn = moveStopEn;
      next_moveStopSt = moveStopSt;
      next_driveCmd   = driveCmd;
      next_rdValid    = read && !rdValid;
      next_readdata   = readdata;
      diff            = 33'sd0;
      prod            = 50'sd0;
      stepUp          = 34'(curVel) + 34'(signed'({2'b00, accel}));
      stepDn          = 34'(curVel) - 34'(signed'({2'b00, accel}));

      // Register bus
      if (read && !rdValid) begin
         if (address == `OFS_CTRL) begin
            next_readdata = ctrl;
         end else if (address == `OFS_STATUS) begin
            next_readdata = {27'h000_0000, state == ST_EXEC, busy, mode};
         end else if (address == `OFS_RESP) begin
            next_readdata = {30'h0000_0000, resp};
         end else if (address == `OFS_DRIVE) begin
            next_readdata = driveCmd;
         end else if (address >= `OFS_DATA_BASE) begin
            next_readdata = dataReg[address[7:2]];
         end else begin
            next_readdata = 32'h0000_0000;
         end
      end
      if (write) begin
         if (address == `OFS_CTRL) begin
            next_ctrl = {30'h0000_0000, writedata[1:0]};
         end else if (address == `OFS_RESP) begin
            next_resp = RESP_NONE;
         end else if (address >= `OFS_DATA_BASE) begin
            for (int b = 0; b < 4; b++) begin
               if (byteenable[b]) begin
                  next_dataReg[address[7:2]][8*b +: 8] = writedata[8*b +: 8];
               end
            end
         end
      end

      // Command word assembly
      case (state)
         ST_COLLECT: begin
            if (cmdWrite) begin
               next_word[cnt] = writedata[15:0];
               if (cnt == 3'd0) begin
                  next_fromProg = (address == `OFS_CMD_PROGRAM);
                  if (writedata[7:0] == `OP_PROG_VEL) begin
                     next_len = `LEN_PROG_VEL;
                  end else if (writedata[7:0] == `OP_TORQUE_IN
                               || writedata[7:0] == `OP_VEL_IN) begin
                     next_len = `LEN_INPUT_MODE;
                  end else if (writedata[7:0] == `OP_REG_ABS_TIME
                               || writedata[7:0] == `OP_REG_ABS_RATE) begin
                     next_len = `LEN_REG_MOVE;
                  end else begin
                     next_len = 3'd1;
                  end
               end
               // Length of this command, fresh on its first word
               if (cnt + 3'd1 == next_len) begin
                  next_state = ST_EXEC;
                  next_cnt   = 3'd0;
               end else begin
                  next_cnt = cnt + 3'd1;
               end
            end
         end
         ST_EXEC: begin
            next_state = ST_COLLECT;
            if (len == 3'd1) begin
               next_resp = RESP_NAK_BAD;
            end else if (!fromProg && (ctrl[`CTRL_PROG_RUN] || busy)) begin
               next_resp = RESP_NAK_BUSY;
            end else if (fromProg && busy && !ctrl[`CTRL_MULTITASK]) begin
               next_state = ST_EXEC;
            end else if (opcode == `OP_PROG_VEL
                         && ({word[1], word[2]} == 32'h0000_0000
                             || {word[1], word[2]} > `ACCEL_MAX)) begin
               next_resp = RESP_NAK_BAD;
            end else if ((opcode == `OP_TORQUE_IN || opcode == `OP_VEL_IN)
                         && word[1] > `FILT_MAX) begin
               next_resp = RESP_NAK_BAD;
            end else if ((opcode == `OP_REG_ABS_TIME || opcode == `OP_REG_ABS_RATE)
                         && word[1] > `REG_MOVE_MAX) begin
               next_resp = RESP_NAK_BAD;
            end else begin
               next_resp      = RESP_ACK;
               next_moveAbort = (mode == MODE_MOVE);
               next_filt      = 32'sd0;
               if (opcode == `OP_TORQUE_IN || opcode == `OP_VEL_IN) begin
                  next_mode   = (opcode == `OP_TORQUE_IN) ? MODE_TORQUE : MODE_VEL_IN;
                  next_filtK  = word[1];
                  next_stopEn = word[2];
                  next_stopSt = word[3];
               end else if (opcode == `OP_PROG_VEL) begin
                  next_mode   = MODE_VEL_PROG;
                  next_accel  = {word[1], word[2]};
                  next_target = {word[3], word[4]};
                  next_stopEn = word[5];
                  next_stopSt = word[6];
                  if (mode != MODE_VEL_PROG) begin
                     next_curVel = 32'sd0;
                  end
               end else begin
                  // Parameters come from N, N+1, N+2; the trajectory unit runs the move
                  next_mode       = MODE_MOVE;
                  next_moveStart  = 1'b1;
                  next_moveTimed  = (opcode == `OP_REG_ABS_TIME);
                  next_movePos    = dataReg[base];
                  next_moveSecond = dataReg[base + `DATA_IDX_W'(1)];
                  next_moveThird  = dataReg[base + `DATA_IDX_W'(2)];
                  next_moveStopEn = word[2];
                  next_moveStopSt = word[3];
                  next_driveCmd   = 32'h0000_0000;
               end
            end
         end
         default: next_state = ST_COLLECT;
      endcase

      // Motion update at the loop rate
      case (mode)
         MODE_TORQUE, MODE_VEL_IN: begin
            if (stopMet) begin
               next_mode     = MODE_IDLE;
               next_driveCmd = 32'h0000_0000;
            end else if (tick) begin
               // Output moves by (1 - K/32768) of the error each period
               diff          = 33'(signed'(dataReg[`INPUT_REG])) - 33'(filt);
               prod          = 50'(diff) * 50'(`FILT_UNITY - 17'(signed'({1'b0, filtK})));
               next_filt     = filt + 32'(prod >>> 15);
               next_driveCmd = next_filt;
            end
         end
         MODE_VEL_PROG: begin
            if (stopMet && target != 32'sd0) begin
               next_target = 32'sd0;
            end
            if (tick) begin
               if (curVel < target) begin
                  next_curVel = (stepUp > 34'(target)) ? target : 32'(stepUp);
               end else if (curVel > target) begin
                  next_curVel = (stepDn < 34'(target)) ? target : 32'(stepDn);
               end
               next_driveCmd = next_curVel;
            end
            if (curVel == 32'sd0 && target == 32'sd0 && next_state != ST_EXEC) begin
               next_mode = MODE_IDLE;
            end
         end
         MODE_MOVE: begin
            if (moveDone && !next_moveStart) begin
               next_mode = MODE_IDLE;
            end
         end
         default: next_mode = next_mode;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `DATA_REGS; i++) begin
            dataReg[i] <= 32'h0000_0000;
         end
         for (int j = 0; j < 7; j++) begin
            word[j] <= 16'h0000;
         end
         ctrl       <= `CTRL_RESET;
         state      <= ST_COLLECT;
         cnt        <= 3'd0;
         len        <= 3'd1;
         fromProg   <= 1'b0;
         resp       <= RESP_NONE;
         mode       <= MODE_IDLE;
         filt       <= 32'sd0;
         filtK      <= 16'h0000;
         stopEn     <= 16'h0000;
         stopSt     <= 16'h0000;
         curVel     <= 32'sd0;
         target     <= 32'sd0;
         accel      <= 32'h0000_0000;
         tickCnt    <= `TICK_W'(0);
         moveStart  <= 1'b0;
         moveAbort  <= 1'b0;
         moveTimed  <= 1'b0;
         movePos    <= 32'h0000_0000;
         moveSecond <= 32'h0000_0000;
         moveThird  <= 32'h0000_0000;
         moveStopEn <= 16'h0000;
         moveStopSt <= 16'h0000;
         driveCmd   <= 32'h0000_0000;
         rdValid    <= 1'b0;
         readdata   <= 32'h0000_0000;
      end else begin
         dataReg    <= next_dataReg;
         word       <= next_word;
         ctrl       <= next_ctrl;
         state      <= next_state;
         cnt        <= next_cnt;
         len        <= next_len;
         fromProg   <= next_fromProg;
         resp       <= next_resp;
         mode       <= next_mode;
         filt       <= next_filt;
         filtK      <= next_filtK;
         stopEn     <= next_stopEn;
         stopSt     <= next_stopSt;
         curVel     <= next_curVel;
         target     <= next_target;
         accel      <= next_accel;
         tickCnt    <= next_tickCnt;
         moveStart  <= next_moveStart;
         moveAbort  <= next_moveAbort;
         moveTimed  <= next_moveTimed;
         movePos    <= next_movePos;
         moveSecond <= next_moveSecond;
         moveThird  <= next_moveThird;
         moveStopEn <= next_moveStopEn;
         moveStopSt <= next_moveStopSt;
         driveCmd   <= next_driveCmd;
         rdValid    <= next_rdValid;
         readdata   <= next_readdata;
      end
   end

   assign driveMode = mode;

endmodule : motion_mode_command_decoder

/* File: inc/motion_consts.svh */
`ifndef MOTION_CONSTS_SVH
`define MOTION_CONSTS_SVH

// Byte offsets on the register bus
`define OFS_CMD_SERIAL   9'h000
`define OFS_CTRL         9'h004
`define OFS_STATUS       9'h008
`define OFS_RESP         9'h00C
`define OFS_DRIVE        9'h010
`define OFS_CMD_PROGRAM  9'h014
`define OFS_DATA_BASE    9'h100
`define OFS_DATA_LAST    9'h1FC

// Control register fields
`define CTRL_MULTITASK   0
`define CTRL_PROG_RUN    1
`define CTRL_RESET       32'h0000_0000

// Opcodes
`define OP_TORQUE_IN     8'hDA
`define OP_VEL_IN        8'hD9
`define OP_PROG_VEL      8'h9F
`define OP_REG_ABS_TIME  8'hEC
`define OP_REG_ABS_RATE  8'hEA

// Command lengths in words
`define LEN_INPUT_MODE   3'd4
`define LEN_PROG_VEL     3'd7
`define LEN_REG_MOVE     3'd4

// Data registers
`define DATA_REGS        64
`define DATA_IDX_W       6
`define INPUT_REG        6'd12
`define REG_MOVE_MAX     16'h003D

// Filter scale and legal range
`define FILT_UNITY       17'sh0_8000
`define FILT_MAX         16'h7FFF
`define ACCEL_MAX        32'h3FFF_FFFF

// Update period
`define UPDATE_NS        120000
`define CLK_NS           100
`define UPDATE_CYC       ((`UPDATE_NS + `CLK_NS - 1) / `CLK_NS)
`define TICK_W           11

`endif

/* File: inc/motion_pkg.sv */
package motion_pkg;

   typedef enum logic [2:0] {
      MODE_IDLE     = 3'b000,
      MODE_TORQUE   = 3'b001,
      MODE_VEL_IN   = 3'b010,
      MODE_VEL_PROG = 3'b011,
      MODE_MOVE     = 3'b100
   } mode_t;

   typedef enum logic [1:0] {
      RESP_NONE     = 2'b00,
      RESP_ACK      = 2'b01,
      RESP_NAK_BUSY = 2'b10,
      RESP_NAK_BAD  = 2'b11
   } resp_t;

   typedef enum logic {
      ST_COLLECT = 1'b0,
      ST_EXEC    = 1'b1
   } eng_state_t;

endpackage : motion_pkg

/* File: tb/motion_chk.sv */
`timescale 1ns/1ps
`include "motion_consts.svh"
module motion_chk (
   // Clock and reset
   input wire logic         ref_clk,
   input wire logic         rst,
   // Register bus
   input wire logic [8:0]   address,
   input wire logic         read,
   input wire logic         write,
   input wire logic         waitrequest,
   // Drive and trajectory
   input motion_pkg::mode_t driveMode,
   input wire logic         moveStart,
   input wire logic         moveAbort,
   input wire logic         moveTimed,
   input wire logic         moveDone
);
   import motion_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RD_TURN: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read not answered on second cycle");
   AST_CTRL_NOWAIT: assert property ((write && address == `OFS_CTRL) |-> !waitrequest)
      else $error("control write stalled");
   AST_START_PULSE: assert property (moveStart |=> !moveStart)
      else $error("move start longer than one cycle");
   AST_START_MODE: assert property (moveStart |-> ##[0:1] driveMode == MODE_MOVE)
      else $error("move start without move mode");
   AST_START_CAUSE: assert property ($rose(moveStart) |-> $past(write, 2) || $past(write, 3))
      else $error("move start without command word");
   AST_DONE_EXIT: assert property ((driveMode == MODE_MOVE && moveDone && !moveStart)
      |-> ##[1:2] driveMode != MODE_MOVE) else $error("move done did not end move");
   AST_TIMED_HOLD: assert property ((driveMode == MODE_MOVE && !moveStart)
      |-> $stable(moveTimed)) else $error("move kind changed during move");
   AST_ABORT_CAUSE: assert property (moveAbort
      |-> $past(driveMode) == MODE_MOVE ##1 !moveAbort) else $error("abort without running move");
endmodule : motion_chk

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "motion_consts.svh"
module tb_top;
   import motion_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [8:0]  address = 9'h000;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata, driveCmd, movePos, moveSecond, moveThird;
   logic        waitrequest, moveStart, moveAbort, moveTimed, moveDone, cTim;
   logic [15:0] stopPins = 16'h0000;
   logic [15:0] moveStopEn, moveStopSt;
   mode_t       driveMode;
   logic        slow = 1'b0;
   logic [15:0] wq[$];
   logic [31:0] rd, cPos, cSec, cThr, cStop;
   int          failures = 0;
   int          checks = 0;
   int          aborts = 0;
   motion_mode_command_decoder DUT (.ref_clk, .rst, .address, .read, .write, .writedata,
      .byteenable(4'hF), .readdata, .waitrequest, .stopPins, .driveMode, .driveCmd,
      .moveStart, .moveAbort, .moveTimed, .movePos, .moveSecond, .moveThird,
      .moveStopEn, .moveStopSt, .moveDone);
   traj_model u_traj (.ref_clk, .rst, .moveStart, .slow, .moveDone);
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (moveStart === 1'b1) begin
         cPos <= movePos;
         cSec <= moveSecond;
         cThr <= moveThird;
         cTim <= moveTimed;
         cStop <= {moveStopSt, moveStopEn};
      end
      if (moveAbort === 1'b1) aborts <= aborts + 1;
   end
   task automatic results;
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tmo(input string n);
      failures++;
      $display("[FAIL] %s expected answer seen timeout", n);
      results();
   endtask : tmo
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge ref_clk);
         n++;
         if (n > 20000) tmo("bus");
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic cmd(input logic [8:0] a, input logic [31:0] e, input string n);
      foreach (wq[i]) bus(1'b1, a, {16'h0000, wq[i]});
      repeat (3) @(posedge ref_clk);
      bus(1'b0, `OFS_RESP, 32'h0000_0000);
      chk(n, e, rd);
   endtask : cmd
   task automatic waitFor(input bit m, input logic [31:0] v, input int lim, input string n);
      int k;
      for (k = 0; k < lim && (m ? 32'(driveMode) : driveCmd) !== v; k++) @(negedge ref_clk);
      if (k >= lim) tmo(n);
      chk(n, v, m ? 32'(driveMode) : driveCmd);
      @(posedge ref_clk);
   endtask : waitFor
   task automatic s_input;
      bus(1'b1, `OFS_DATA_BASE + 9'h030, 32'h0000_1234);
      wq = '{{8'h00, `OP_TORQUE_IN}, 16'h0000, 16'h0001, 16'h0001};
      cmd(`OFS_CMD_SERIAL, 32'h0000_0001, "torque ack");
      waitFor(1'b1, MODE_TORQUE, 3, "torque mode");
      waitFor(1'b0, 32'h0000_1234, 1300, "torque filter");
      wq = '{{8'h00, `OP_VEL_IN}, 16'h0000, 16'h0000, 16'h0000};
      cmd(`OFS_CMD_SERIAL, 32'h0000_0002, "busy nak");
      stopPins <= 16'h0001;
      waitFor(1'b1, MODE_IDLE, 20, "torque stop");
      stopPins <= 16'h0000;
      bus(1'b1, `OFS_DATA_BASE + 9'h030, 32'h0000_0ABC);
      wq = '{{8'h00, `OP_VEL_IN}, 16'h8000, 16'h0001, 16'h0001};
      cmd(`OFS_CMD_SERIAL, 32'h0000_0003, "filter range");
      wq[1] = 16'h4000;
      cmd(`OFS_CMD_SERIAL, 32'h0000_0001, "vel in ack");
      waitFor(1'b1, MODE_VEL_IN, 3, "vel in mode");
      // Half weight: each period closes half of the remaining error
      waitFor(1'b0, 32'h0000_055E, 1300, "vel in filter");
      waitFor(1'b0, 32'h0000_080D, 1300, "vel in filter two");
      stopPins <= 16'h0001;
      waitFor(1'b1, MODE_IDLE, 20, "vel in stop");
      stopPins <= 16'h0000;
   endtask : s_input
   task automatic s_prog;
      wq = '{{8'h00, `OP_PROG_VEL}, 16'h0000, 16'h0000, 16'h0000, 16'h01F4, 16'h0002, 16'h0002};
      cmd(`OFS_CMD_SERIAL, 32'h0000_0003, "accel zero");
      wq[1] = 16'h4000;
      cmd(`OFS_CMD_SERIAL, 32'h0000_0003, "accel high");
      wq[1] = 16'h0000;
      wq[2] = 16'h0064;
      cmd(`OFS_CMD_SERIAL, 32'h0000_0001, "prog vel ack");
      waitFor(1'b0, 32'h0000_0064, 1300, "ramp step");
      waitFor(1'b0, 32'h0000_00C8, 1300, "ramp step two");
      waitFor(1'b0, 32'h0000_01F4, 4000, "ramp top");
      cmd(`OFS_CMD_SERIAL, 32'h0000_0002, "motion busy");
      stopPins <= 16'h0002;
      waitFor(1'b0, 32'h0000_0190, 1300, "stop ramp");
      waitFor(1'b1, MODE_IDLE, 6000, "stop end");
      chk("stop vel", 32'h0000_0000, driveCmd);
      stopPins <= 16'h0000;
      bus(1'b1, `OFS_CTRL, 32'h0000_0003);
      wq[4] = 16'h012C;
      wq[5] = 16'h0000;
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0001, "program ack");
      cmd(`OFS_CMD_SERIAL, 32'h0000_0002, "program busy");
      waitFor(1'b0, 32'h0000_0064, 1300, "program ramp");
      wq[4] = 16'h0000;
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0001, "replace ack");
      chk("still moving", MODE_VEL_PROG, 32'(driveMode));
      waitFor(1'b1, MODE_IDLE, 2600, "shut down");
      chk("shut vel", 32'h0000_0000, driveCmd);
   endtask : s_prog
   task automatic s_move;
      int a0;
      bus(1'b1, `OFS_CTRL, 32'h0000_0000);
      for (int i = 0; i < 3; i++) bus(1'b1, `OFS_DATA_BASE + 9'h078 + 9'(4 * i), 32'hA000_0000 + i);
      for (int j = 0; j < 2; j++) begin
         wq = '{{8'h00, (j == 1) ? `OP_REG_ABS_RATE : `OP_REG_ABS_TIME}, 16'h001E, 16'h0005,
                16'h0001};
         cmd(`OFS_CMD_SERIAL, 32'h0000_0001, "move ack");
         chk("move timed", 32'(j == 0), 32'(cTim));
         chk("move pos", 32'hA000_0000, cPos);
         chk("move second", 32'hA000_0001, cSec);
         chk("move third", 32'hA000_0002, cThr);
         chk("move stop", 32'h0001_0005, cStop);
         waitFor(1'b1, MODE_IDLE, 100, "move end");
      end
      wq[1] = 16'h003E;
      cmd(`OFS_CMD_SERIAL, 32'h0000_0003, "start reg range");
      bus(1'b1, `OFS_CTRL, 32'h0000_0003);
      slow <= 1'b1;
      wq[1] = 16'h001E;
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0001, "slow move ack");
      a0 = aborts;
      wq[0] = {8'h00, `OP_REG_ABS_TIME};
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0001, "takeover ack");
      chk("abort count", 32'(a0 + 1), 32'(aborts));
      chk("takeover timed", 32'h0000_0001, 32'(cTim));
      waitFor(1'b1, MODE_IDLE, 2600, "takeover end");
      // Without multitasking a program command waits for the running move
      bus(1'b1, `OFS_CTRL, 32'h0000_0002);
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0001, "wait move ack");
      bus(1'b1, `OFS_RESP, 32'h0000_0000);
      wq = '{{8'h00, `OP_PROG_VEL}, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      cmd(`OFS_CMD_PROGRAM, 32'h0000_0000, "program waits");
      chk("move kept", MODE_MOVE, 32'(driveMode));
      waitFor(1'b1, MODE_VEL_PROG, 2600, "queued vel");
      bus(1'b0, `OFS_RESP, 32'h0000_0000);
      chk("queued ack", 32'h0000_0001, rd);
      waitFor(1'b1, MODE_IDLE, 20, "queued end");
   endtask : s_move
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      s_input();
      s_prog();
      s_move();
      results();
   end
endmodule : tb_top
bind motion_mode_command_decoder motion_chk u_chk (.ref_clk, .rst, .address, .read, .write,
   .waitrequest, .driveMode, .moveStart, .moveAbort, .moveTimed, .moveDone);

/* File: tb/traj_model.sv */
`timescale 1ns/1ps
module traj_model #(
   parameter int FAST = 20,
   parameter int SLOW = 2000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Trajectory handshake
   input wire logic moveStart,
   input wire logic slow,
   output logic     moveDone
);
   int left;
   // A new start restarts the count, so a replaced move reports done only if the start lands on its last count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         left <= 0;
         moveDone <= 1'b0;
      end else begin
         moveDone <= (left == 1);
         if (moveStart) left <= slow ? SLOW : FAST;
         else if (left > 0) left <= left - 1;
      end
   end
endmodule : traj_model
